// [logic/smbus_eeprom_access.v]
// Purpose: master SMBus control and software byte access to a serial EEPROM
// Assumes: APB slave at 50 MHz; bus pins are open drain, sampled by two flops
// Notes: control register survives warm reset except the timeout disable bit, which WARM_RST_N clears; the rest is cleared only by RST_N
`timescale 1ns/1ps
`include "smbus_eeprom_defines.vh"
module smbus_eeprom_access #(
  parameter [6:0] EEPROM_DEV_ADDR = 7'h50,
  parameter TIMEOUT_CYCLES = (`TIMEOUT_MS * 1000000) / `CLK_PERIOD_NS
) (
  input wire CLOCK,
  input wire RST_N,
  input wire WARM_RST_N,
  input wire CE,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  output wire [31:0] PRDATA,
  output wire PREADY,
  output wire PSLVERR,
  input wire SCL_IN,
  output wire SCL_OUT,
  output wire SCL_OE,
  input wire SDA_IN,
  output wire SDA_OUT,
  output wire SDA_OE,
  input wire INIT_CHECKSUM_BAD,
  output wire CHECKSUM_ERROR,
  output wire TIMEOUT_DISABLE
);
  localparam ST_IDLE = 4'h0;
  localparam ST_START = 4'h1;
  localparam ST_BYTE = 4'h2;
  localparam ST_ACK = 4'h3;
  localparam ST_RESTART = 4'h4;
  localparam ST_STOP = 4'h5;
  localparam ST_DONE = 4'h6;
  localparam ST_RETRY = 4'h7;
  localparam [2:0] PH_DEV = 3'h0;
  localparam [2:0] PH_AHI = 3'h1;
  localparam [2:0] PH_ALO = 3'h2;
  localparam [2:0] PH_WDAT = 3'h3;
  localparam [2:0] PH_RDEV = 3'h4;
  localparam [2:0] PH_RDAT = 3'h5;
  localparam [15:0] UNIT_NUM = `PRESCALE_UNIT_NS;
  localparam [15:0] CLK_NS = `CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////////
  // helpers
  function [31:0] quarter_cycles;
    input [15:0] div;
    reg [31:0] ns;
    begin
      ns = {16'h0000, div} * {16'h0000, UNIT_NUM};
      quarter_cycles = (ns + {16'h0000, CLK_NS} * 32'h4 - 32'h1) / ({16'h0000, CLK_NS} * 32'h4);
      if (quarter_cycles == 32'h0) begin
        quarter_cycles = 32'h1;
      end
    end
  endfunction

  function [7:0] byte_for_phase;
    input [2:0] ph;
    input [15:0] addr;
    input [7:0] data;
    begin
      case (ph)
        PH_DEV: byte_for_phase = {EEPROM_DEV_ADDR, 1'b0};
        PH_AHI: byte_for_phase = addr[15:8];
        PH_ALO: byte_for_phase = addr[7:0];
        PH_WDAT: byte_for_phase = data;
        PH_RDEV: byte_for_phase = {EEPROM_DEV_ADDR, 1'b1};
        default: byte_for_phase = 8'hFF;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  reg scl_m_ff, scl_s_ff, sda_m_ff, sda_s_ff;
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      scl_m_ff <= 1'b1;
      scl_s_ff <= 1'b1;
      sda_m_ff <= 1'b1;
      sda_s_ff <= 1'b1;
    end else if (CE) begin
      scl_m_ff <= SCL_IN;
      scl_s_ff <= scl_m_ff;
      sda_m_ff <= SDA_IN;
      sda_s_ff <= sda_m_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers
  reg [15:0] divider_ff;
  reg ignore_masters_ff, skip_checksum_ff, timeout_dis_ff;
  reg [15:0] addr_ff;
  reg [7:0] data_ff;
  reg op_ff, done_ff, nack_ff, arb_ff;
  reg [3:0] state_ff;
  wire busy = (state_ff != ST_IDLE);
  wire wr_acc = PSEL & PENABLE & PWRITE;
  wire hit_ctl = (PADDR == `OFS_SMBUS_MASTER_CONTROL);
  wire hit_acc = (PADDR == `OFS_EEPROM_BYTE_ACCESS);
  wire hit_sts = (PADDR == `OFS_SMBUS_STATUS);
  wire start_op = CE & wr_acc & hit_acc & !busy;
  wire op_done;
  wire op_nack;
  wire op_arb;
  wire [7:0] rd_byte;

  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & !(hit_ctl | hit_acc | hit_sts);
  assign PRDATA = !(PSEL & !PWRITE) ? 32'h00000000 :
    hit_ctl ? {9'h000, timeout_dis_ff, 4'h0, skip_checksum_ff, ignore_masters_ff, divider_ff} :
    hit_acc ? {5'h00, op_ff, done_ff, busy, data_ff, addr_ff} :
    hit_sts ? {3'h0, CHECKSUM_ERROR, 1'b0, arb_ff, nack_ff, 25'h0000000} :
    32'h00000000;
  assign TIMEOUT_DISABLE = timeout_dis_ff;
  assign CHECKSUM_ERROR = INIT_CHECKSUM_BAD & !skip_checksum_ff;

  // sticky control: only the fundamental reset clears it
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      divider_ff <= `DIVIDER_RESET;
      ignore_masters_ff <= 1'b0;
      skip_checksum_ff <= 1'b0;
    end else if (CE && wr_acc && hit_ctl) begin
      divider_ff <= PWDATA[15:0];
      ignore_masters_ff <= PWDATA[`CTL_IGNORE_MASTERS_BIT];
      skip_checksum_ff <= PWDATA[`CTL_SKIP_CHECKSUM_BIT];
    end
  end

  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      timeout_dis_ff <= 1'b0;
      addr_ff <= 16'h0000;
      data_ff <= 8'h00;
      op_ff <= `OP_WRITE;
      done_ff <= 1'b0;
      nack_ff <= 1'b0;
      arb_ff <= 1'b0;
    end else if (!WARM_RST_N) begin
      timeout_dis_ff <= 1'b0;
      addr_ff <= 16'h0000;
      data_ff <= 8'h00;
      op_ff <= `OP_WRITE;
      done_ff <= 1'b0;
      nack_ff <= 1'b0;
      arb_ff <= 1'b0;
    end else if (CE) begin
      if (wr_acc && hit_ctl) begin
        timeout_dis_ff <= PWDATA[`CTL_TIMEOUT_DISABLE_BIT];
      end
      if (wr_acc && hit_acc && !busy) begin
        addr_ff <= PWDATA[15:0];
        data_ff <= PWDATA[23:16];
        op_ff <= PWDATA[`ACC_OP_BIT];
      end
      if (op_done && op_ff == `OP_READ) begin
        data_ff <= rd_byte;
      end
      if (op_done) begin
        done_ff <= 1'b1;
      end else if (start_op || (wr_acc && hit_acc && PWDATA[`ACC_DONE_BIT])) begin
        done_ff <= 1'b0;
      end
      if (op_nack) begin
        nack_ff <= 1'b1;
      end else if (wr_acc && hit_sts && PWDATA[`STS_NACK_BIT]) begin
        nack_ff <= 1'b0;
      end
      if (op_arb) begin
        arb_ff <= 1'b1;
      end else if (wr_acc && hit_sts && PWDATA[`STS_ARB_BIT]) begin
        arb_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // bit timer: four quarters per bus clock period
  reg [31:0] tick_cnt_ff;
  reg [1:0] quarter_ff;
  wire clk_run = (divider_ff > 16'h0001);
  wire tick = clk_run && (tick_cnt_ff == 32'h0);
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      tick_cnt_ff <= 32'h0;
    end else if (CE) begin
      if (!busy || !clk_run || tick_cnt_ff == 32'h0) begin
        tick_cnt_ff <= quarter_cycles(divider_ff) - 32'h1;
      end else begin
        tick_cnt_ff <= tick_cnt_ff - 32'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // transaction engine
  reg [2:0] phase_ff;
  reg [2:0] bit_ff;
  reg [7:0] shift_ff;
  reg [4:0] losses_ff;
  reg scl_low_ff, sda_low_ff;
  reg nack_p_ff, arb_p_ff;
  reg [31:0] idle_cnt_ff;
  assign op_done = tick && (state_ff == ST_DONE) && !timed_out;
  assign op_nack = nack_p_ff;
  assign op_arb = arb_p_ff;
  assign rd_byte = shift_ff;
  assign SCL_OUT = 1'b0;
  assign SDA_OUT = 1'b0;
  assign SCL_OE = scl_low_ff;
  assign SDA_OE = sda_low_ff;
  wire reading = (phase_ff == PH_RDAT);
  wire lost = sda_low_ff == 1'b0 && sda_s_ff == 1'b0 && !reading;
  wire timed_out = !timeout_dis_ff && idle_cnt_ff >= TIMEOUT_CYCLES;

  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      state_ff <= ST_IDLE;
      phase_ff <= PH_DEV;
      bit_ff <= 3'h7;
      shift_ff <= 8'h00;
      quarter_ff <= 2'h0;
      losses_ff <= 5'h00;
      scl_low_ff <= 1'b0;
      sda_low_ff <= 1'b0;
      nack_p_ff <= 1'b0;
      arb_p_ff <= 1'b0;
      idle_cnt_ff <= 32'h0;
    end else if (CE) begin
      nack_p_ff <= 1'b0;
      arb_p_ff <= 1'b0;
      idle_cnt_ff <= (busy && !scl_s_ff && !scl_low_ff) ? idle_cnt_ff + 32'h1 : 32'h0;
      if (start_op) begin
        state_ff <= ST_START;
        phase_ff <= PH_DEV;
        quarter_ff <= 2'h0;
        losses_ff <= 5'h00;
      end else if (busy && timed_out) begin
        state_ff <= ST_STOP;
        nack_p_ff <= 1'b1;
        quarter_ff <= 2'h0;
      end else if (tick) begin
        quarter_ff <= quarter_ff + 2'h1;
        case (state_ff)
          ST_START, ST_RESTART: begin
            case (quarter_ff)
              2'h0: sda_low_ff <= 1'b0;
              2'h1: scl_low_ff <= 1'b0;
              2'h2: sda_low_ff <= 1'b1;
              default: begin
                scl_low_ff <= 1'b1;
                state_ff <= ST_BYTE;
                bit_ff <= 3'h7;
                shift_ff <= byte_for_phase(phase_ff, addr_ff, data_ff);
              end
            endcase
          end
          ST_BYTE, ST_ACK: begin
            case (quarter_ff)
              2'h0: begin
                scl_low_ff <= 1'b1;
                if (state_ff == ST_ACK) begin
                  sda_low_ff <= reading ? 1'b0 : 1'b0;
                end else begin
                  sda_low_ff <= reading ? 1'b0 : !shift_ff[7];
                end
              end
              2'h1: scl_low_ff <= 1'b0;
              2'h2: quarter_ff <= scl_s_ff ? 2'h3 : 2'h2;
              default: begin
                scl_low_ff <= 1'b1;
                if (state_ff == ST_BYTE) begin
                  if (lost && !ignore_masters_ff) begin
                    state_ff <= ST_RETRY;
                  end else begin
                    shift_ff <= {shift_ff[6:0], reading ? sda_s_ff : 1'b0};
                    bit_ff <= bit_ff - 3'h1;
                    if (bit_ff == 3'h0) begin
                      state_ff <= ST_ACK;
                    end
                  end
                end else if (reading) begin
                  state_ff <= ST_STOP;
                end else if (sda_s_ff) begin
                  nack_p_ff <= 1'b1;
                  state_ff <= ST_STOP;
                end else if (phase_ff == PH_WDAT) begin
                  state_ff <= ST_STOP;
                end else if (phase_ff == PH_ALO && op_ff == `OP_READ) begin
                  phase_ff <= PH_RDEV;
                  state_ff <= ST_RESTART;
                end else if (phase_ff == PH_RDEV) begin
                  phase_ff <= PH_RDAT;
                  state_ff <= ST_BYTE;
                  bit_ff <= 3'h7;
                end else begin
                  phase_ff <= phase_ff + 3'h1;
                  state_ff <= ST_BYTE;
                  bit_ff <= 3'h7;
                  shift_ff <= byte_for_phase(phase_ff + 3'h1, addr_ff, data_ff);
                end
              end
            endcase
          end
          ST_RETRY: begin
            scl_low_ff <= (quarter_ff == 2'h0) ? scl_low_ff : 1'b0;
            sda_low_ff <= (quarter_ff == 2'h0) ? sda_low_ff : 1'b0;
            if (losses_ff == `ARB_RETRY_LIMIT - 5'h1) begin
              arb_p_ff <= 1'b1;
              state_ff <= ST_IDLE;
            end else if (quarter_ff == 2'h3 && scl_s_ff && sda_s_ff) begin
              losses_ff <= losses_ff + 5'h1;
              phase_ff <= PH_DEV;
              state_ff <= ST_START;
            end
          end
          ST_STOP: begin
            case (quarter_ff)
              2'h0, 2'h1: begin
                scl_low_ff <= 1'b1;
                sda_low_ff <= 1'b1;
              end
              2'h2: scl_low_ff <= 1'b0;
              default: begin
                sda_low_ff <= 1'b0;
                state_ff <= ST_DONE;
              end
            endcase
          end
          ST_DONE: begin
            state_ff <= ST_IDLE;
          end
          default: state_ff <= ST_IDLE;
        endcase
      end
    end
  end
endmodule

// [logic/smbus_eeprom_defines.vh]
// Purpose: constants for the master SMBus control and EEPROM byte access block
// Assumes: 50 MHz core clock, APB register bus with 32-bit data
// Notes: offsets are byte addresses
`ifndef SMBUS_EEPROM_DEFINES_VH
`define SMBUS_EEPROM_DEFINES_VH
`define OFS_SMBUS_MASTER_CONTROL 12'h428
`define OFS_EEPROM_BYTE_ACCESS 12'h42C
`define OFS_SMBUS_STATUS 12'h424
`define CLK_PERIOD_NS 20
`define PRESCALE_UNIT_NS 32
`define DIVIDER_RESET 16'h0053
`define CTL_IGNORE_MASTERS_BIT 16
`define CTL_SKIP_CHECKSUM_BIT 17
`define CTL_TIMEOUT_DISABLE_BIT 22
`define ACC_BUSY_BIT 24
`define ACC_DONE_BIT 25
`define ACC_OP_BIT 26
`define STS_NACK_BIT 25
`define STS_ARB_BIT 26
`define STS_CHECKSUM_BIT 28
`define ARB_RETRY_LIMIT 5'h10
`define TIMEOUT_MS 25
`define OP_WRITE 1'b0
`define OP_READ 1'b1
`endif

// [tb/smbus_eeprom_access_props.sv]
// Purpose: port checks for the smbus eeprom access block
// Assumes: one clock, bound to the top module
// Notes: divider and skip bit mirrored from apb writes
`timescale 1ns/1ps
`include "smbus_eeprom_defines.vh"
module smbus_eeprom_access_props (
  input wire CLOCK,
  input wire RST_N,
  input wire WARM_RST_N,
  input wire CE,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  input wire [31:0] PRDATA,
  input wire PREADY,
  input wire PSLVERR,
  input wire SCL_OE,
  input wire SDA_OE,
  input wire INIT_CHECKSUM_BAD,
  input wire CHECKSUM_ERROR,
  input wire TIMEOUT_DISABLE
);
  logic [15:0] div_ff;
  logic skip_ff;
  logic [31:0] low_ff;
  wire acc = PSEL && PENABLE && CE;
  wire is_ctl = PADDR == `OFS_SMBUS_MASTER_CONTROL;
  wire is_acc = PADDR == `OFS_EEPROM_BYTE_ACCESS;
  wire mapped = is_ctl || is_acc || PADDR == `OFS_SMBUS_STATUS;
  wire wr_ctl = acc && PWRITE && is_ctl;
  wire [31:0] qtr = ({16'h0, div_ff} * 32'h20 + 32'h4F) / 32'h50;
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);
  ////////////////////////////////////////
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      div_ff <= `DIVIDER_RESET;
      skip_ff <= 1'b0;
      low_ff <= 32'h0;
    end else begin
      low_ff <= SCL_OE ? low_ff + 32'h1 : 32'h0;
      if (wr_ctl) begin
        div_ff <= PWDATA[15:0];
        skip_ff <= PWDATA[`CTL_SKIP_CHECKSUM_BIT];
      end
    end
  end
  ////////////////////////////////////////
  sequence s_ctl_write;
    wr_ctl && WARM_RST_N ##1 WARM_RST_N && CE;
  endsequence
  sequence s_stopped;
    div_ff < 16'h2 ##1 div_ff < 16'h2 && WARM_RST_N;
  endsequence
  AST_READY: assert property (acc |-> PREADY)
    else $error("ready low");
  AST_SLVERR: assert property (acc |-> PSLVERR == !mapped)
    else $error("slverr wrong");
  AST_CHECKSUM: assert property (CHECKSUM_ERROR == (INIT_CHECKSUM_BAD && !skip_ff))
    else $error("checksum wrong");
  AST_TMO: assert property (s_ctl_write |=> TIMEOUT_DISABLE == $past(PWDATA[22], 2))
    else $error("timeout copy wrong");
  AST_DIV: assert property (PSEL && !PWRITE && is_ctl |-> PRDATA[15:0] == div_ff)
    else $error("divider wrong");
  AST_BUSY_DONE: assert property (PSEL && !PWRITE && is_acc |-> !(PRDATA[24] && PRDATA[25]))
    else $error("busy with done");
  AST_STOP: assert property (s_stopped |=> $stable(SCL_OE) && $stable(SDA_OE))
    else $error("bus moved");
  AST_LOW: assert property ($fell(SCL_OE) && $past(WARM_RST_N) |-> low_ff >= 2 * qtr)
    else $error("low too short");
endmodule
bind smbus_eeprom_access smbus_eeprom_access_props u_props (
  .CLOCK(CLOCK), .RST_N(RST_N), .WARM_RST_N(WARM_RST_N), .CE(CE),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .SCL_OE(SCL_OE), .SDA_OE(SDA_OE), .INIT_CHECKSUM_BAD(INIT_CHECKSUM_BAD),
  .CHECKSUM_ERROR(CHECKSUM_ERROR), .TIMEOUT_DISABLE(TIMEOUT_DISABLE)
);

// [tb/eeprom_model.sv]
// Purpose: serial eeprom on the master smbus
// Assumes: open drain lines resolved by the bench
// Notes: one data byte per read; absent leaves address unanswered
`timescale 1ns/1ps
module eeprom_model (
  input wire scl,
  input wire sda,
  input wire absent,
  input wire [31:0] hold_ns,
  output logic scl_oe,
  output logic sda_oe
);
  logic [7:0] mem [0:65535];
  logic [7:0] sh;
  logic [15:0] addr;
  logic act = 1'b0;
  logic rd = 1'b0;
  int bitn = 0;
  int byten = 0;
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end
  ////////////////////////////////////////
  always @(negedge sda) if (scl) begin
    act = 1'b1;
    rd = 1'b0;
    bitn = 0;
    byten = 0;
  end
  always @(posedge sda) if (scl) act = 1'b0;
  always @(posedge scl) if (act) begin
    if (!rd || byten == 0) sh = {sh[6:0], sda};
    bitn = bitn + 1;
  end
  always @(negedge scl) if (act) begin
    if (bitn == 8 && (!rd || byten == 0)) begin
      if (byten == 0) rd = sh[0];
      if (byten == 1) addr[15:8] = sh;
      if (byten == 2) addr[7:0] = sh;
      if (byten == 3) mem[addr] = sh;
      sda_oe = !absent && (byten > 0 || sh[7:1] == 7'h50);
      if (hold_ns > 0) begin
        scl_oe = 1'b1;
        #(hold_ns);
        scl_oe = 1'b0;
      end
    end else if (bitn == 9) begin
      bitn = 0;
      byten = byten + 1;
      if (rd && byten == 1) sh = mem[addr];
      sda_oe = rd && byten == 1 && !sh[7];
    end else if (rd && byten == 1) begin
      sda_oe = bitn < 8 && !sh[7 - bitn];
    end
  end
endmodule

// [tb/smbus_eeprom_access_tb_top.sv]
// Purpose: self-checking bench for the smbus eeprom access block
// Assumes: divider two for fast traffic, short time-out
// Notes: apb master holds each request until pready
`timescale 1ns/1ps
`include "smbus_eeprom_defines.vh"
module smbus_eeprom_access_tb_top;
  localparam logic [11:0] CTL = `OFS_SMBUS_MASTER_CONTROL;
  localparam logic [11:0] ACC = `OFS_EEPROM_BYTE_ACCESS;
  localparam logic [11:0] STS = `OFS_SMBUS_STATUS;
  logic CLOCK = 1'b0;
  logic RST_N = 1'b0;
  logic WARM_RST_N = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic INIT_CHECKSUM_BAD = 1'b0;
  logic absent = 1'b0;
  logic [11:0] PADDR = 12'h0;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] rdat;
  logic rerr;
  int hold_ns = 0;
  int n_fail = 0;
  int n_compared = 0;
  int cycles = 0;
  wire [31:0] PRDATA;
  wire PREADY, PSLVERR, SCL_OUT, SCL_OE, SDA_OUT, SDA_OE, CHECKSUM_ERROR, TIMEOUT_DISABLE;
  wire m_scl_oe, m_sda_oe;
  wire scl = !((SCL_OE && !SCL_OUT) || m_scl_oe);
  wire sda = !((SDA_OE && !SDA_OUT) || m_sda_oe);
  smbus_eeprom_access #(.TIMEOUT_CYCLES(200)) dut (
    .CLOCK(CLOCK), .RST_N(RST_N), .WARM_RST_N(WARM_RST_N), .CE(1'b1),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .SCL_IN(scl), .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE), .SDA_IN(sda),
    .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .INIT_CHECKSUM_BAD(INIT_CHECKSUM_BAD),
    .CHECKSUM_ERROR(CHECKSUM_ERROR), .TIMEOUT_DISABLE(TIMEOUT_DISABLE)
  );
  eeprom_model u_mem (
    .scl(scl), .sda(sda), .absent(absent), .hold_ns(hold_ns),
    .scl_oe(m_scl_oe), .sda_oe(m_sda_oe)
  );
  ////////////////////////////////////////
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    @(posedge CLOCK);
    while (PREADY !== 1'b1) @(posedge CLOCK);
    rdat = PRDATA;
    rerr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_idle();
    do apb(1'b0, ACC, 32'h0);
    while (rdat[24] !== 1'b0);
  endtask
  task automatic finish_test();
    if (n_fail == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  task automatic t_reset();
    apb(1'b0, CTL, 32'h0);
    chk(rdat, 32'h00000053);
    apb(1'b0, ACC, 32'h0);
    chk(rdat, 32'h0);
    apb(1'b0, 12'h500, 32'h0);
    chk(rerr, 1'b1);
  endtask
  task automatic t_ctl();
    INIT_CHECKSUM_BAD <= 1'b1;
    @(negedge CLOCK);
    chk(CHECKSUM_ERROR, 1'b1);
    apb(1'b1, CTL, 32'h00430002);
    repeat (2) @(negedge CLOCK);
    chk(CHECKSUM_ERROR, 1'b0);
    chk(TIMEOUT_DISABLE, 1'b1);
    @(posedge CLOCK);
    WARM_RST_N <= 1'b0;
    @(posedge CLOCK);
    WARM_RST_N <= 1'b1;
    apb(1'b0, CTL, 32'h0);
    chk(rdat, 32'h00030002);
    chk(TIMEOUT_DISABLE, 1'b0);
  endtask
  task automatic t_xfer();
    apb(1'b1, ACC, 32'h00A51234);
    apb(1'b1, ACC, 32'h04FF0042);
    apb(1'b0, ACC, 32'h0);
    chk(rdat, 32'h01A51234);
    wait_idle();
    chk(rdat, 32'h02A51234);
    chk(u_mem.mem[16'h1234], 8'hA5);
    apb(1'b1, ACC, 32'h06001234);
    apb(1'b0, ACC, 32'h0);
    chk(rdat[26:24], 3'b101);
    wait_idle();
    chk(rdat, 32'h06A51234);
  endtask
  task automatic t_nack();
    absent <= 1'b1;
    apb(1'b1, ACC, 32'h02000010);
    wait_idle();
    chk(rdat[25], 1'b1);
    apb(1'b0, STS, 32'h0);
    chk(rdat[26:25], 2'b01);
    apb(1'b1, STS, 32'h06000000);
    apb(1'b0, STS, 32'h0);
    chk(rdat[26:25], 2'b00);
    absent <= 1'b0;
  endtask
  task automatic t_stop();
    apb(1'b1, CTL, 32'h00000001);
    apb(1'b1, ACC, 32'h02330020);
    repeat (200) @(posedge CLOCK);
    apb(1'b0, ACC, 32'h0);
    chk(rdat[25:24], 2'b01);
    apb(1'b1, CTL, 32'h00000002);
    wait_idle();
    chk(u_mem.mem[16'h0020], 8'h33);
  endtask
  task automatic t_slow();
    for (int b = 1; b >= 0; b--) begin
      hold_ns <= 6000;
      apb(1'b1, CTL, b ? 32'h00400002 : 32'h00000002);
      apb(1'b1, ACC, b ? 32'h02770030 : 32'h02660030);
      wait_idle();
      apb(1'b0, STS, 32'h0);
      chk(rdat[25], !b);
      chk(u_mem.mem[16'h0030], 8'h77);
      apb(1'b1, STS, 32'h02000000);
    end
  endtask
  ////////////////////////////////////////
  initial begin
    forever #10 CLOCK = ~CLOCK;
  end
  always @(posedge CLOCK) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_fail = n_fail + 1;
      finish_test();
    end
  end
  initial begin
    repeat (6) @(posedge CLOCK);
    RST_N <= 1'b1;
    t_reset();
    t_ctl();
    t_xfer();
    t_nack();
    t_stop();
    t_slow();
    finish_test();
  end
endmodule
